// >>> mrp_misc_bank.sv
// misc routing, pin function and power mode register bank behind an axi4-lite slave
// Notes on behaviour
// - strap low forces core reset active
// - pin bit1 picks infrared or scan outputs
// - pin bit2 picks smbus port1 or ps2 port3
// - spi clock input as slave, output as master
// - spi select input as slave, output as master
// - mode1: four-wire y on channel 0
// - mode4: four-wire x on channel 1
// - mode5: five-wire y on channel 4
// - mode6: five-wire x on channel 4
// - join bits link smbus pairs, reset zero
// - four 2-bit port fields, reset 0x55
// - host smbus port select, 11 reserved
// - two external ports unless SMB_PORTS is 3
// - status bit0 low in stop, reset 0x01
// - power bit7 write enters stop mode
// - power bit6 write enters idle mode
// - power bit3 resets core during stop
// - power bit2 lets watchdog wake stop
// - power bit1 lets general event wake stop
// - power bit0 lets interrupt wake idle
`default_nettype none
module mrp_misc_bank #(
  parameter int unsigned SMB_PORTS = 2    // external smbus ports, 2 or 3
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [mrp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [mrp_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       reset_force_strap,
  input  wire logic                       watchdog_irq,
  input  wire logic                       general_wake_event,
  input  wire logic                       core_irq_any,
  output logic                            core_reset_n,
  output logic                            core_stop,
  output logic                            core_idle,
  output logic                            scan_out_sel,
  output logic                            keyboard_port_three_sel,
  output logic                            spi_clk_oe_n,
  output logic                            spi_cs_oe_n,
  output mrp_pkg::mrp_panel_type          panel_drive,
  output logic [2:0]                      smbus_join,
  output mrp_pkg::mrp_route_type          smbus_route,
  output logic [2:0]                      host_port_en
);
  import mrp_pkg::*;

  mrp_state_type st_r;     // registered state
  mrp_state_type st_nxt;   // next state
  logic          wr_go;    // both write halves held, response free

  // refuse port counts the routing cannot serve
  if (SMB_PORTS < 2 || SMB_PORTS > 3) begin : g_bad_ports
    $error("SMB_PORTS must be 2 or 3");
  end

  // reset image of the whole state
  localparam mrp_state_type ST_RST = '{
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
    aw_addr: '0, aw_held: 1'b0, w_data: '0, w_strb: '0, w_held: 1'b0,
    arready: 1'b1, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY,
    join_en: RST_SMB_JOIN[2:0], route: RST_SMB_ROUTE, host_rt: RST_HOST_RT,
    host_en: 3'h1, power: RST_POWER, panel_mode: RST_PANEL, panel: '0,
    pinfn: RST_PINFN, spi_master: RST_SPI_MST, pstate: PWR_RUN,
    strap_valid: 1'b0, strap_low: 1'b0, core_reset_n: 1'b0};

  // true for any mapped register; shared by read and write paths
  function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
    logic [5:0] i;
    i = a[AXI_AW-1:2];
    if (i == IDX_SMB_JOIN) begin
      return 1'b1;
    end else if (i == IDX_SMB_ROUTE || i == IDX_HOST_RT || i == IDX_RUN_STAT) begin
      return 1'b1;
    end else if (i == IDX_POWER || i == IDX_PANEL || i == IDX_PINFN) begin
      return 1'b1;
    end else if (i == IDX_SPI_CFG) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // read image of one register; reserved and write-only bits are zero
  function automatic logic [7:0] read_reg(input logic [AXI_AW-1:0] a,
                                          input mrp_state_type s);
    logic [5:0] i;
    i = a[AXI_AW-1:2];
    if (i == IDX_SMB_JOIN) begin
      return {5'h00, s.join_en};
    end else if (i == IDX_SMB_ROUTE) begin
      return s.route;
    end else if (i == IDX_HOST_RT) begin
      return {6'h00, s.host_rt};
    end else if (i == IDX_RUN_STAT) begin
      return {7'h00, ~s.pstate[2]};
    end else if (i == IDX_POWER) begin
      return {4'h0, s.power};
    end else if (i == IDX_PANEL) begin
      return {s.panel_mode, 4'h0};
    end else if (i == IDX_PINFN) begin
      return {5'h00, s.pinfn, 1'b0};
    end else if (i == IDX_SPI_CFG) begin
      return {7'h00, s.spi_master};
    end else begin
      return 8'h00;
    end
  endfunction

  // channel drive pattern for each panel mode
  function automatic mrp_panel_type panel_decode(input logic [3:0] m);
    mrp_panel_type p;
    p = '0;
    case (m)
      PANEL_Y4: begin
        p.chan   = 3'h0;
        p.vcc[1] = 1'b1;
        p.gnd[3] = 1'b1;
      end
      PANEL_Z1: begin
        p.chan   = 3'h0;
        p.vcc[1] = 1'b1;
        p.gnd[2] = 1'b1;
      end
      PANEL_Z2: begin
        p.chan   = 3'h3;
        p.vcc[1] = 1'b1;
        p.gnd[2] = 1'b1;
      end
      PANEL_X4: begin
        p.chan   = 3'h1;
        p.vcc[0] = 1'b1;
        p.gnd[2] = 1'b1;
      end
      PANEL_Y5: begin
        p.chan = 3'h4;
        p.vcc  = 5'h03;
        p.gnd  = 5'h0C;
      end
      PANEL_X5: begin
        p.chan = 3'h4;
        p.vcc  = 5'h05;
        p.gnd  = 5'h0A;
      end
      PANEL_PEN4: begin
        p.chan    = 3'h0;
        p.pull[0] = 1'b1;
        p.gnd[3]  = 1'b1;
      end
      PANEL_PEN5: begin
        p.chan    = 3'h4;
        p.pull[4] = 1'b1;
        p.gnd[3]  = 1'b1;
      end
      default: begin                     // plain converter use, all drivers off
        p = '0;
      end
    endcase
    return p;
  endfunction

  assign wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;

  // next-state logic for bus, registers and power state
  always_comb begin
    logic [5:0] wi;
    logic       lane0;
    wi     = st_r.aw_addr[AXI_AW-1:2];
    lane0  = st_r.w_strb[0];
    st_nxt = st_r;
    // write address and data are taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_addr = s_axi_awaddr;
      st_nxt.aw_held = 1'b1;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_data  = s_axi_wdata;
      st_nxt.w_strb  = s_axi_wstrb;
      st_nxt.w_held  = 1'b1;
      st_nxt.wready  = 1'b0;
    end
    // response accepted: reopen both write channels
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid  = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
    end
    // power state: wake conditions first, a write below may override
    case (st_r.pstate)
      PWR_IDLE: begin
        if (core_irq_any && st_r.power[PWR_IWAKE_BIT]) begin
          st_nxt.pstate = PWR_RUN;
        end
      end
      PWR_STOP: begin
        if ((watchdog_irq && st_r.power[PWR_WDOG_BIT]) ||
            (general_wake_event && st_r.power[PWR_GWAKE_BIT])) begin
          st_nxt.pstate = PWR_RUN;
        end
      end
      default: begin
        st_nxt.pstate = st_r.pstate;
      end
    endcase
    // register write; only byte lane 0 carries data
    if (wr_go) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = addr_mapped(st_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (!lane0) begin
        st_nxt.bresp = st_nxt.bresp;                   // no lane 0: nothing stored
      end else if (wi == IDX_SMB_JOIN) begin
        st_nxt.join_en = st_r.w_data[2:0];
      end else if (wi == IDX_SMB_ROUTE) begin
        st_nxt.route = st_r.w_data[7:0];
      end else if (wi == IDX_HOST_RT) begin
        st_nxt.host_rt = st_r.w_data[1:0];
      end else if (wi == IDX_POWER) begin
        st_nxt.power = st_r.w_data[3:0];
        if (st_r.w_data[PWR_STOP_BIT]) begin
          st_nxt.pstate = PWR_STOP;
        end else if (st_r.w_data[PWR_IDLE_BIT]) begin
          st_nxt.pstate = PWR_IDLE;
        end
      end else if (wi == IDX_PANEL) begin
        st_nxt.panel_mode = st_r.w_data[PANEL_LSB +: 4];
      end else if (wi == IDX_PINFN) begin
        st_nxt.pinfn = st_r.w_data[PIN_SMPS_BIT:PIN_IRKB_BIT];
      end else if (wi == IDX_SPI_CFG) begin
        st_nxt.spi_master = st_r.w_data[SPI_MST_BIT];
      end
    end
    // read channel: one outstanding read, answered the cycle after acceptance
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b1;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = {24'h000000, read_reg(s_axi_araddr, st_r)};
      st_nxt.rresp   = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // strap caught once, in the first cycle after reset release
    if (!st_r.strap_valid) begin
      st_nxt.strap_valid = 1'b1;
      st_nxt.strap_low   = ~reset_force_strap;
    end
    // core reset: held until strap known, forced by strap or stop with reset enabled
    st_nxt.core_reset_n = st_nxt.strap_valid && !st_nxt.strap_low &&
                          !(st_nxt.pstate[2] && st_nxt.power[PWR_CRST_BIT]);
    // host device controller: port 2 exists only on the three-port variant
    case (st_nxt.host_rt)
      2'h0: st_nxt.host_en = 3'h1;
      2'h1: st_nxt.host_en = 3'h2;
      2'h2: st_nxt.host_en = (SMB_PORTS == 3) ? 3'h4 : 3'h0;
      default: st_nxt.host_en = 3'h0;                                        // reserved code
    endcase
    // panel pattern follows the stored mode one cycle later
    st_nxt.panel = panel_decode(st_r.panel_mode);
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs are flop bits of the state record, the two spi enables inverted ones
  assign s_axi_awready           = st_r.awready;
  assign s_axi_wready            = st_r.wready;
  assign s_axi_bvalid            = st_r.bvalid;
  assign s_axi_bresp             = st_r.bresp;
  assign s_axi_arready           = st_r.arready;
  assign s_axi_rvalid            = st_r.rvalid;
  assign s_axi_rdata             = st_r.rdata;
  assign s_axi_rresp             = st_r.rresp;
  assign core_reset_n            = st_r.core_reset_n;
  assign core_stop               = st_r.pstate[2];
  assign core_idle               = st_r.pstate[1];
  assign scan_out_sel            = st_r.pinfn[0];
  assign keyboard_port_three_sel = st_r.pinfn[1];
  // master drives both pins; slave leaves them as inputs
  assign spi_clk_oe_n            = ~st_r.spi_master;
  assign spi_cs_oe_n             = ~st_r.spi_master;
  assign panel_drive             = st_r.panel;
  assign smbus_join              = st_r.join_en;
  assign smbus_route             = st_r.route;
  assign host_port_en            = st_r.host_en;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strap_core_reset: assert property (st_r.strap_valid && st_r.strap_low
      |-> !core_reset_n)
    else $error("core reset released while strap low");
  a_pin_scan_select: assert property (wr_go && st_r.aw_addr[7:2] == IDX_PINFN
      && st_r.w_strb[0] |=> scan_out_sel == $past(st_r.w_data[1])
      && keyboard_port_three_sel == $past(st_r.w_data[2]))
    else $error("pin function select not taken from write");
  a_spi_dir_pair: assert property (wr_go && st_r.aw_addr[7:2] == IDX_SPI_CFG
      && st_r.w_strb[0] |=> spi_clk_oe_n == !$past(st_r.w_data[SPI_MST_BIT])
      && spi_cs_oe_n == !$past(st_r.w_data[SPI_MST_BIT]))
    else $error("spi clock and select directions not taken from write");
  a_panel_y_four: assert property (st_r.panel_mode == PANEL_Y4
      |=> panel_drive.chan == 3'h0 && panel_drive.vcc == 5'h02 && panel_drive.gnd == 5'h08)
    else $error("panel mode 1 drive wrong");
  a_panel_five_x: assert property (st_r.panel_mode == PANEL_X5
      |=> panel_drive.chan == 3'h4 && panel_drive.vcc == 5'h05 && panel_drive.gnd == 5'h0A)
    else $error("panel mode 6 drive wrong");
  a_host_two_ports: assert property (SMB_PORTS == 2
      |-> host_port_en[2] == 1'b0 && $onehot0(host_port_en))
    else $error("host smbus port 2 enabled on two-port part");
  a_stop_entry: assert property (wr_go && st_r.aw_addr[7:2] == IDX_POWER
      && st_r.w_strb[0] && st_r.w_data[PWR_STOP_BIT] |=> core_stop)
    else $error("stop not entered");
  a_idle_entry: assert property (wr_go && st_r.aw_addr[7:2] == IDX_POWER
      && st_r.w_strb[0] && !st_r.w_data[PWR_STOP_BIT] && st_r.w_data[PWR_IDLE_BIT]
      |=> core_idle)
    else $error("idle not entered");
  a_stop_core_reset: assert property (core_stop && st_r.power[PWR_CRST_BIT]
      |-> !core_reset_n)
    else $error("core not reset in stop");
  a_watchdog_wake: assert property (core_stop && watchdog_irq
      && st_r.power[PWR_WDOG_BIT] && !wr_go |=> !core_stop)
    else $error("watchdog did not wake stop");
  a_general_wake: assert property (core_stop && general_wake_event
      && st_r.power[PWR_GWAKE_BIT] && !wr_go |=> !core_stop)
    else $error("general wake event did not wake stop");
  a_idle_wake: assert property (core_idle && core_irq_any
      && st_r.power[PWR_IWAKE_BIT] && !wr_go |=> !core_idle)
    else $error("interrupt did not wake idle");
  a_join_write: assert property (wr_go && st_r.aw_addr[7:2] == IDX_SMB_JOIN
      && st_r.w_strb[0] |=> smbus_join == $past(st_r.w_data[2:0]))
    else $error("smbus join not taken from write");
  a_route_write: assert property (wr_go && st_r.aw_addr[7:2] == IDX_SMB_ROUTE
      && st_r.w_strb[0] |=> smbus_route == $past(st_r.w_data[7:0]))
    else $error("smbus port route not taken from write");
  a_status_read: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[7:2] == IDX_RUN_STAT
      |=> s_axi_rvalid && s_axi_rdata == {31'h0, !$past(core_stop)})
    else $error("run status read wrong");
  a_power_wo_zero: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[7:2] == IDX_POWER |=> s_axi_rdata[31:4] == 28'h0)
    else $error("power mode entry bits read nonzero");

  c_stop_entered: cover property (!core_stop ##1 core_stop);
  c_idle_woken: cover property (core_idle ##1 !core_idle);
  c_write_answered: cover property (s_axi_bvalid && s_axi_bready);
  c_status_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata[0] == 1'b0);
  c_strap_hold: cover property (st_r.strap_valid && st_r.strap_low);
endmodule
`default_nettype wire

// >>> mrp_pkg.sv
// package: register map, field layout and state record of the misc routing and power bank
`default_nettype none
package mrp_pkg;
  // bus geometry
  localparam int unsigned AXI_AW = 8;                // byte address width seen by the slave
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_SMB_JOIN  = 6'h01;      // smbus_internal_join
  localparam logic [5:0] IDX_SMB_ROUTE = 6'h02;      // smbus_controller_port_route
  localparam logic [5:0] IDX_HOST_RT   = 6'h03;      // host_smbus_port_route
  localparam logic [5:0] IDX_RUN_STAT  = 6'h05;      // core_run_status
  localparam logic [5:0] IDX_POWER     = 6'h0A;      // power_mode_control
  localparam logic [5:0] IDX_PANEL     = 6'h26;      // panel drive mode, bits 7..4
  localparam logic [5:0] IDX_PINFN     = 6'h28;      // pin_function_select
  localparam logic [5:0] IDX_SPI_CFG   = 6'h2C;      // spi role
  // reset values
  localparam logic [7:0] RST_SMB_JOIN  = 8'h00;
  localparam logic [7:0] RST_SMB_ROUTE = 8'h55;
  localparam logic [1:0] RST_HOST_RT   = 2'h0;
  localparam logic [7:0] RST_RUN_STAT  = 8'h01;
  localparam logic [3:0] RST_POWER     = 4'h0;
  localparam logic [3:0] RST_PANEL     = 4'h0;
  localparam logic [1:0] RST_PINFN     = 2'h0;
  localparam logic       RST_SPI_MST   = 1'b0;
  // field positions
  localparam int unsigned PWR_STOP_BIT   = 7;        // write-only
  localparam int unsigned PWR_IDLE_BIT   = 6;        // write-only
  localparam int unsigned PWR_CRST_BIT   = 3;
  localparam int unsigned PWR_WDOG_BIT   = 2;
  localparam int unsigned PWR_GWAKE_BIT  = 1;
  localparam int unsigned PWR_IWAKE_BIT  = 0;
  localparam int unsigned PIN_IRKB_BIT   = 1;
  localparam int unsigned PIN_SMPS_BIT   = 2;
  localparam int unsigned PANEL_LSB      = 4;
  localparam int unsigned SPI_MST_BIT    = 0;
  // panel drive modes
  localparam logic [3:0] PANEL_ADC  = 4'h0;
  localparam logic [3:0] PANEL_Y4   = 4'h1;
  localparam logic [3:0] PANEL_Z1   = 4'h2;
  localparam logic [3:0] PANEL_Z2   = 4'h3;
  localparam logic [3:0] PANEL_X4   = 4'h4;
  localparam logic [3:0] PANEL_Y5   = 4'h5;
  localparam logic [3:0] PANEL_X5   = 4'h6;
  localparam logic [3:0] PANEL_PEN4 = 4'h7;
  localparam logic [3:0] PANEL_PEN5 = 4'h8;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // core power states, one-hot
  typedef enum logic [2:0] {
    PWR_RUN  = 3'b001,
    PWR_IDLE = 3'b010,
    PWR_STOP = 3'b100
  } mrp_pwr_state_type;
  // analog channel drivers, one bit per channel 0..4
  typedef struct packed {
    logic [4:0] vcc;     // driven to supply
    logic [4:0] gnd;     // driven to ground
    logic [4:0] pull;    // weak pull-up for pen detect
    logic [2:0] chan;    // converter input channel
  } mrp_panel_type;
  // port selection of the four smbus controllers
  typedef struct packed {
    logic [1:0] master1;
    logic [1:0] master0;
    logic [1:0] slave1;
    logic [1:0] slave0;
  } mrp_route_type;
  // whole state of the bank
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic [AXI_AW-1:0] aw_addr;
    logic              aw_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_held;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [2:0]        join_en;
    mrp_route_type     route;
    logic [1:0]        host_rt;
    logic [2:0]        host_en;
    logic [3:0]        power;
    logic [3:0]        panel_mode;
    mrp_panel_type     panel;
    logic [1:0]        pinfn;
    logic              spi_master;
    mrp_pwr_state_type pstate;
    logic              strap_valid;
    logic              strap_low;
    logic              core_reset_n;
  } mrp_state_type;
endpackage
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the misc routing and power bank over axi4-lite
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mrp_pkg::*;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic              strap, wdog, gwake, irq_any;
  logic              core_reset_n, core_stop, core_idle, scan_sel, kb3_sel, clk_oe_n, cs_oe_n;
  mrp_panel_type     panel;
  logic [2:0]        join_o, host_en;
  mrp_route_type     route;
  logic [33:0]       rq[$];      // expected {rresp, rdata}
  logic [1:0]        bq[$];      // expected bresp
  int                n_fail, checks, cyc;
  logic [7:0]        rv;
  logic [33:0]       r_exp;      // oldest read note
  logic [1:0]        b_exp;      // oldest write note
  logic [17:0]       pan_exp[4] = '{18'h04800, 18'h02401, 18'h06C04, 18'h0AA04};
  logic [3:0]        pan_mode[4] = '{4'h1, 4'h4, 4'h5, 4'h6};
  logic [2:0]        host_exp[4] = '{3'h1, 3'h2, 3'h0, 3'h0};
  mrp_misc_bank #(.SMB_PORTS(2)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reset_force_strap(strap), .watchdog_irq(wdog), .general_wake_event(gwake),
    .core_irq_any(irq_any), .core_reset_n(core_reset_n), .core_stop(core_stop),
    .core_idle(core_idle), .scan_out_sel(scan_sel), .keyboard_port_three_sel(kb3_sel),
    .spi_clk_oe_n(clk_oe_n), .spi_cs_oe_n(cs_oe_n), .panel_drive(panel),
    .smbus_join(join_o), .smbus_route(route), .host_port_en(host_en));
  // free-running clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // hang guard, far above the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  // monitor: looks mid-cycle, where the flop outputs stand settled before the edge
  always @(negedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      r_exp = rq.pop_front();
      `CHK({rresp, rdata}, r_exp)
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      b_exp = bq.pop_front();
      `CHK(bresp, b_exp)
    end
  end
  // write: address and data offered together, each released after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r = RESP_OKAY, input logic [3:0] s = 4'hF);
    logic aw_go, w_go, b_go;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h000000, d}; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    b_go = 1'b0;
    while (!b_go) begin
      @(negedge aclk);
      aw_go = awvalid && awready === 1'b1;
      w_go  = wvalid && wready === 1'b1;
      b_go  = bvalid === 1'b1;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (b_go) bready <= 1'b0;
    end
  endtask
  // read: expectation noted, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    logic ar_go, r_go;
    rq.push_back({r, 24'h000000, d});
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    r_go = 1'b0;
    while (!r_go) begin
      @(negedge aclk);
      ar_go = arvalid && arready === 1'b1;
      r_go  = rvalid === 1'b1;
      @(posedge aclk);
      if (ar_go) arvalid <= 1'b0;
      if (r_go) rready <= 1'b0;
    end
  endtask
  // let register effects reach the outputs before looking
  task automatic settle(input int n = 2);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    @(posedge aclk);
    aresetn <= 1'b0; strap <= s;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle(3);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, wdog, gwake, irq_any} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    aresetn = 1'b0; strap = 1'b1; n_fail = 0; checks = 0; cyc = 0;
    void'($urandom(32'h078ecc7e));
    do_reset(1'b1);
    `CHK(core_reset_n, 1'b1)
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h55);
    rd(8'h14, 8'h01);
    rd(8'h28, 8'h00);
    $display("reset values done");
    wr(8'h04, 8'hFF); rd(8'h04, 8'h07);
    settle(); `CHK(join_o, 3'h7)
    wr(8'h04, 8'h00, RESP_OKAY, 4'h0); rd(8'h04, 8'h07);
    rv = 8'($urandom());
    wr(8'h08, rv); rd(8'h08, rv);
    settle(); `CHK(route, rv)
    for (int i = 0; i < 4; i++) begin
      wr(8'h0C, 8'hFC | 8'(i)); rd(8'h0C, 8'(i));
      settle(); `CHK(host_en, host_exp[i])
    end
    wr(8'h14, 8'h00, RESP_OKAY); rd(8'h14, 8'h01);
    wr(8'h3C, 8'h12, RESP_SLVERR); rd(8'h3C, 8'h00, RESP_SLVERR);
    $display("smbus routing done");
    for (int i = 0; i < 4; i++) begin
      wr(8'hA0, 8'hF9 | 8'(i << 1)); rd(8'hA0, 8'(i << 1));
      settle(); `CHK({kb3_sel, scan_sel}, 2'(i))
    end
    for (int i = 0; i < 2; i++) begin
      wr(8'hB0, 8'(i));
      settle(); `CHK({clk_oe_n, cs_oe_n}, {2{~1'(i)}})
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h98, {pan_mode[i], 4'h0});
      settle(); `CHK(panel, pan_exp[i])
    end
    $display("pins and panel done");
    wr(8'h28, 8'h88); settle(1); `CHK({core_stop, core_reset_n}, 2'b10)
    rd(8'h28, 8'h08); rd(8'h14, 8'h00);
    wr(8'h28, 8'h84); @(posedge aclk); wdog <= 1'b1;
    settle(3); `CHK(core_stop, 1'b0)
    wr(8'h28, 8'h82); settle(3); `CHK(core_stop, 1'b1)
    @(posedge aclk); gwake <= 1'b1; wdog <= 1'b0;
    settle(3); `CHK(core_stop, 1'b0)
    @(posedge aclk); gwake <= 1'b0; irq_any <= 1'b1;
    wr(8'h28, 8'h40); settle(3); `CHK(core_idle, 1'b1)
    wr(8'h28, 8'h41); settle(3); `CHK(core_idle, 1'b0)
    rd(8'h28, 8'h01);
    @(posedge aclk); irq_any <= 1'b0;
    $display("power modes done");
    do_reset(1'b0);
    settle(5); `CHK(core_reset_n, 1'b0)
    $display("strap done");
    settle(3);
    end_of_test();
  end
endmodule
`default_nettype wire
